// [rtl/sspa_consts.svh]
/*
  Constants of the serial to PCM adapter: offsets, fields, reset values
  and timing counts.
  Assumes a 40 MHz system clock and an 8 MHz port tick.
*/
`ifndef SSPA_CONSTS_SVH
`define SSPA_CONSTS_SVH

// ********************************************************************
// Register map (byte addresses, one word each)
// ********************************************************************
`define SSPA_CTRL_OFS 4'h0
`define SSPA_STATUS_OFS 4'h4
`define SSPA_MASK_OFS 4'h8
`define SSPA_LOC_OFS 4'hc

// ********************************************************************
// Field positions
// ********************************************************************
`define SSPA_CF_RATE56 0
`define SSPA_CF_DTE 8
`define SSPA_CF_REVERSE 16
`define SSPA_CF_LOOP 24
`define SSPA_ST_TXLOC 0
`define SSPA_ST_RXLOC 8
`define SSPA_ST_SLIP 16

// ********************************************************************
// Reset values
// ********************************************************************
`define SSPA_CTRL_RST 32'h0000_0000
`define SSPA_MASK_RST 24'h00_0000

// ********************************************************************
// Timing
// ********************************************************************
`define SSPA_SYS_HZ 40000000
`define SSPA_TICK_HZ 8000000
`define SSPA_TICK_DIV (`SSPA_SYS_HZ / `SSPA_TICK_HZ)
`define SSPA_RATE64_BPS 64000
`define SSPA_RATE56_BPS 56000
`define SSPA_PERIOD64_TICKS (`SSPA_TICK_HZ / `SSPA_RATE64_BPS)
`define SSPA_PERIOD56_TICKS (`SSPA_TICK_HZ / `SSPA_RATE56_BPS)
`define SSPA_LOC_WINDOW_TICKS (2 * `SSPA_PERIOD56_TICKS)

`endif

// [rtl/sspa_pkg.sv]
/*
  Types of the serial port adapter: per-port state and whole-block state.
  Assumes the constants header is included by the design file.
*/
package sspa_pkg;

  // ******************************************************************
  // Per-port state
  // ******************************************************************
  typedef struct packed {
    logic [1:0] txc_p;
    logic [1:0] txc_n;
    logic txc_prev;
    logic [1:0] rxc_p;
    logic [1:0] rxc_n;
    logic rxc_prev;
    logic [1:0] rxd_p;
    logic [1:0] rxd_n;
    logic [7:0] div_cnt;
    logic clk;
    logic [2:0] tx_idx;
    logic [7:0] tx_byte;
    logic tx_bit;
    logic tx_rd;
    logic [2:0] rx_idx;
    logic [7:0] rx_raw;
    logic [7:0] rx_out;
    logic rx_wr;
    logic [8:0] txloc_cnt;
    logic [8:0] rxloc_cnt;
    logic tx_loc;
    logic rx_loc;
  } port_type;

  // ******************************************************************
  // Block state
  // ******************************************************************
  typedef struct packed {
    port_type [7:0] port;
    logic [2:0] tick_cnt;
    logic [31:0] ctrl;
    logic [23:0] status;
    logic [23:0] mask;
    logic ack;
    logic [31:0] rdata;
  } state_type;

endpackage : sspa_pkg

// [rtl/sync_serial_pcm_port_adapter.sv]
/*
  Eight-port synchronous serial to PCM adapter with an Avalon-MM register
  slave and one level interrupt.
  Assumes show-ahead PCM FIFOs on the same clock, line receivers ahead of
  the pos/neg pins, and a pin wrapper that resolves the clock pin enables.
*/
`timescale 1ns/100ps
`include "sspa_consts.svh"

module sync_serial_pcm_port_adapter #(
  parameter logic [8:0] LOC_WINDOW = 9'(`SSPA_LOC_WINDOW_TICKS)
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [7:0] transmit_clock_pos_seen,
  input wire logic [7:0] transmit_clock_neg_seen,
  output logic [7:0] transmit_clock_pos_drive,
  output logic [7:0] transmit_clock_neg_drive,
  output logic [7:0] transmit_clock_pos_enable,
  output logic [7:0] transmit_clock_neg_enable,
  input wire logic [7:0] receive_clock_pos_seen,
  input wire logic [7:0] receive_clock_neg_seen,
  output logic [7:0] receive_clock_pos_drive,
  output logic [7:0] receive_clock_neg_drive,
  output logic [7:0] receive_clock_pos_enable,
  output logic [7:0] receive_clock_neg_enable,
  output logic [7:0] transmit_serial_pos,
  output logic [7:0] transmit_serial_neg,
  input wire logic [7:0] receive_serial_pos,
  input wire logic [7:0] receive_serial_neg,
  output logic [63:0] pcm_rx_byte,
  output logic [7:0] pcm_rx_write,
  input wire logic [7:0] pcm_rx_room,
  input wire logic [63:0] pcm_tx_byte,
  output logic [7:0] pcm_tx_read,
  input wire logic [7:0] pcm_tx_avail,
  output logic [23:0] clock_absent_detect
);
  import sspa_pkg::*;

  // ******************************************************************
  // Local constants
  // ******************************************************************
  localparam logic [2:0] TICK_LAST = 3'(`SSPA_TICK_DIV - 1);
  localparam logic [7:0] P64 = 8'(`SSPA_PERIOD64_TICKS);
  localparam logic [7:0] P56 = 8'(`SSPA_PERIOD56_TICKS);

  // ******************************************************************
  // Functions
  // ******************************************************************

  // Packs the shifted-in bits (last bit in bit 0) into a PCM byte.
  function automatic logic [7:0] pack_byte(input logic [7:0] raw,
                                           input logic r56,
                                           input logic rev);
    logic [7:0] b;
    b = r56 ? {raw[6:0], 1'b0} : raw;
    if (rev) begin
      for (int k = 0; k < 8; k++) begin
        b[k] = raw[7 - k];
      end
      if (r56) begin
        b[0] = 1'b0;
      end
    end
    return b;
  endfunction : pack_byte

  // Picks serial bit k (0 is sent first) out of a PCM byte.
  function automatic logic unpack_bit(input logic [7:0] b,
                                      input logic [2:0] k,
                                      input logic r56,
                                      input logic rev);
    logic [2:0] pos;
    pos = rev ? 3'(k + {2'b00, r56}) : 3'(3'd7 - k);
    return b[pos];
  endfunction : unpack_bit

  // Merges a write into a register under the byte enables.
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = wd[8*k +: 8];
      end
    end
    return r;
  endfunction : merge_be

  state_type q;
  state_type d;
  logic tick;
  logic [7:0] rate56;
  logic [7:0] dte;
  logic [7:0] rev;
  logic [7:0] loop;

  assign rate56 = q.ctrl[`SSPA_CF_RATE56 +: 8];
  assign dte = q.ctrl[`SSPA_CF_DTE +: 8];
  assign rev = q.ctrl[`SSPA_CF_REVERSE +: 8];
  assign loop = q.ctrl[`SSPA_CF_LOOP +: 8];
  assign tick = (q.tick_cnt == TICK_LAST);

  // ******************************************************************
  // Next-state logic
  // ******************************************************************

  // All pins are resynchronised first; every port then runs on the one
  // system clock, paced by the 8 MHz tick in the source role and by its received clock edges in the follower role.
  always_comb begin
    logic [23:0] set;
    logic [23:0] clr;
    logic [7:0] per;
    logic [2:0] last;
    logic txc;
    logic rxc;
    logic rxd;
    logic tx_fall;
    logic rx_rise;
    logic tx_edge;
    logic rx_edge;
    logic [7:0] nxt;
    set = '0;
    clr = '0;
    per = '0;
    last = '0;
    txc = 1'b0;
    rxc = 1'b0;
    rxd = 1'b0;
    tx_fall = 1'b0;
    rx_rise = 1'b0;
    tx_edge = 1'b0;
    rx_edge = 1'b0;
    nxt = '0;
    d = q;
    d.tick_cnt = tick ? 3'h0 : 3'(q.tick_cnt + 3'h1);
    for (int i = 0; i < 8; i++) begin
      d.port[i].txc_p = {q.port[i].txc_p[0], transmit_clock_pos_seen[i]};
      d.port[i].txc_n = {q.port[i].txc_n[0], transmit_clock_neg_seen[i]};
      d.port[i].rxc_p = {q.port[i].rxc_p[0], receive_clock_pos_seen[i]};
      d.port[i].rxc_n = {q.port[i].rxc_n[0], receive_clock_neg_seen[i]};
      d.port[i].rxd_p = {q.port[i].rxd_p[0], receive_serial_pos[i]};
      d.port[i].rxd_n = {q.port[i].rxd_n[0], receive_serial_neg[i]};
      txc = q.port[i].txc_p[1] & ~q.port[i].txc_n[1];
      rxc = q.port[i].rxc_p[1] & ~q.port[i].rxc_n[1];
      rxd = q.port[i].rxd_p[1] & ~q.port[i].rxd_n[1];
      d.port[i].txc_prev = txc;
      d.port[i].rxc_prev = rxc;
      tx_edge = txc ^ q.port[i].txc_prev;
      rx_edge = rxc ^ q.port[i].rxc_prev;
      per = rate56[i] ? P56 : P64;
      last = rate56[i] ? 3'h6 : 3'h7;
      d.port[i].rx_wr = 1'b0;
      d.port[i].tx_rd = 1'b0;
      // Source role: one divider makes both port clocks, so the whole path
      // is locked to the system clock. Received clocks only ever pace
      // their own port and reach nothing else.
      if (tick) begin
        d.port[i].div_cnt = (q.port[i].div_cnt >= per - 8'h1) ? 8'h0 :
                            8'(q.port[i].div_cnt + 8'h1);
      end
      d.port[i].clk = (q.port[i].div_cnt >= (per >> 1));
      if (dte[i]) begin
        tx_fall = q.port[i].txc_prev & ~txc;
        rx_rise = ~q.port[i].rxc_prev & rxc;
      end else begin
        tx_fall = tick && q.port[i].div_cnt == 8'h0;
        rx_rise = tick && q.port[i].div_cnt == (per >> 1);
      end
      // Transmit shift register: a byte is fetched when the first bit
      // goes out. An empty FIFO repeats the previous byte; only the follower role records a slip.
      if (tx_fall) begin
        nxt = q.port[i].tx_byte;
        if (q.port[i].tx_idx == 3'h0) begin
          if (pcm_tx_avail[i]) begin
            nxt = pcm_tx_byte[8*i +: 8];
            d.port[i].tx_rd = 1'b1;
            if (loop[i]) begin
              d.port[i].rx_out = nxt;
              d.port[i].rx_wr = pcm_rx_room[i];
            end
          end else if (dte[i]) begin
            set[`SSPA_ST_SLIP + i] = 1'b1;
          end
        end
        d.port[i].tx_byte = nxt;
        d.port[i].tx_bit = unpack_bit(nxt, q.port[i].tx_idx, rate56[i],
                                      rev[i]);
        d.port[i].tx_idx = (q.port[i].tx_idx >= last) ? 3'h0 :
                           3'(q.port[i].tx_idx + 3'h1);
      end
      if (loop[i]) begin
        d.port[i].tx_bit = rxd;
      end
      // Receive shift register: a full byte goes to the FIFO unless the
      // port is looped; a full FIFO drops it and, in the follower role, records a slip.
      if (rx_rise) begin
        d.port[i].rx_raw = {q.port[i].rx_raw[6:0], rxd};
        if (q.port[i].rx_idx >= last) begin
          d.port[i].rx_idx = 3'h0;
          if (!loop[i]) begin
            if (pcm_rx_room[i]) begin
              d.port[i].rx_out = pack_byte(d.port[i].rx_raw, rate56[i],
                                           rev[i]);
              d.port[i].rx_wr = 1'b1;
            end else if (dte[i]) begin
              set[`SSPA_ST_SLIP + i] = 1'b1;
            end
          end
        end else begin
          d.port[i].rx_idx = 3'(q.port[i].rx_idx + 3'h1);
        end
      end
      // Clock-loss watch: counts ticks without an edge, saturating at the
      // window. The source role holds it clear and raises nothing.
      if (!dte[i]) begin
        d.port[i].txloc_cnt = 9'h0;
        d.port[i].rxloc_cnt = 9'h0;
      end else begin
        if (tx_edge) begin
          d.port[i].txloc_cnt = 9'h0;
        end else if (tick && q.port[i].txloc_cnt < LOC_WINDOW) begin
          d.port[i].txloc_cnt = 9'(q.port[i].txloc_cnt + 9'h1);
        end
        if (rx_edge) begin
          d.port[i].rxloc_cnt = 9'h0;
        end else if (tick && q.port[i].rxloc_cnt < LOC_WINDOW) begin
          d.port[i].rxloc_cnt = 9'(q.port[i].rxloc_cnt + 9'h1);
        end
      end
      d.port[i].tx_loc = (d.port[i].txloc_cnt == LOC_WINDOW);
      d.port[i].rx_loc = (d.port[i].rxloc_cnt == LOC_WINDOW);
      if (dte[i] && d.port[i].tx_loc != q.port[i].tx_loc) begin
        set[`SSPA_ST_TXLOC + i] = 1'b1;
      end
      if (dte[i] && d.port[i].rx_loc != q.port[i].rx_loc) begin
        set[`SSPA_ST_RXLOC + i] = 1'b1;
      end
    end
    // Register slave: the first cycle of a request latches read data and
    // raises the acknowledge; writes land on the acknowledged edge.
    d.ack = (avs_read | avs_write) & ~q.ack;
    if (avs_read && !q.ack) begin
      case (avs_address)
        `SSPA_CTRL_OFS: d.rdata = q.ctrl;
        `SSPA_STATUS_OFS: begin
          d.rdata = {8'h00, q.status};
          clr = q.status;
        end
        `SSPA_MASK_OFS: d.rdata = {8'h00, q.mask};
        `SSPA_LOC_OFS: begin
          for (int i = 0; i < 8; i++) begin
            d.rdata[i] = q.port[i].tx_loc;
            d.rdata[8 + i] = q.port[i].rx_loc;
          end
          d.rdata[31:16] = 16'h0000;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && q.ack) begin
      case (avs_address)
        `SSPA_CTRL_OFS: d.ctrl = merge_be(q.ctrl, avs_writedata,
                                          avs_byteenable);
        `SSPA_MASK_OFS: d.mask = 24'(merge_be({8'h00, q.mask},
                                    avs_writedata, avs_byteenable));
        default: d.mask = q.mask;
      endcase
    end
    // A fresh event beats the clear of a status read in the same cycle.
    d.status = (q.status & ~clr) | set;
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.ctrl <= `SSPA_CTRL_RST;
      q.mask <= `SSPA_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  // Clock pins are driven only in the source role; each pair is
  // complementary.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      transmit_clock_pos_drive[i] = q.port[i].clk;
      transmit_clock_neg_drive[i] = ~q.port[i].clk;
      receive_clock_pos_drive[i] = q.port[i].clk;
      receive_clock_neg_drive[i] = ~q.port[i].clk;
      transmit_serial_pos[i] = q.port[i].tx_bit;
      transmit_serial_neg[i] = ~q.port[i].tx_bit;
      pcm_rx_byte[8*i +: 8] = q.port[i].rx_out;
      pcm_rx_write[i] = q.port[i].rx_wr;
      pcm_tx_read[i] = q.port[i].tx_rd;
      clock_absent_detect[i] = q.port[i].tx_loc;
      clock_absent_detect[8 + i] = q.port[i].rx_loc;
    end
    transmit_clock_pos_enable = ~dte;
    transmit_clock_neg_enable = ~dte;
    receive_clock_pos_enable = ~dte;
    receive_clock_neg_enable = ~dte;
    clock_absent_detect[23:16] = q.status[`SSPA_ST_SLIP +: 8];
    avs_readdata = q.rdata;
    avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    irq = |(q.status & q.mask);
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  for (genvar g = 0; g < 8; g++) begin : g_chk
    logic rx_line;
    assign rx_line = q.port[g].rxd_p[1] & ~q.port[g].rxd_n[1];

    sequence source_held;
      !dte[g] [*2];
    endsequence
    sequence loop_held;
      loop[g] [*2];
    endsequence

    dce_no_loc_a: assert property (source_held |->
      !q.port[g].tx_loc && !q.port[g].rx_loc && !q.status[g])
      else $error("clock loss shown in source role");
    dce_no_slip_a: assert property (source_held |->
      !$rose(q.status[`SSPA_ST_SLIP + g]))
      else $error("slip recorded in source role");
    dce_clk_high_a: assert property ($rose(q.port[g].clk)
      |-> q.port[g].clk [*8] ##0 transmit_clock_pos_enable[g] || dte[g])
      else $error("generated port clock high too short");
    dte_no_drive_a: assert property (dte[g] |->
      !transmit_clock_pos_enable[g] && !receive_clock_neg_enable[g])
      else $error("clock pin driven in follower role");
    loop_bypass_a: assert property (loop_held |->
      transmit_serial_pos[g] == $past(rx_line))
      else $error("looped transmit data not received data");
    lsb_zero56_a: assert property (pcm_rx_write[g] &&
      $past(rate56[g]) |-> !pcm_rx_byte[8*g])
      else $error("bit 0 not zero at 56 kbps");
    pcm_loop_a: assert property (pcm_tx_read[g] && $past(loop[g])
      && $past(pcm_rx_room[g]) |-> pcm_rx_write[g])
      else $error("PCM byte not looped back");
    loc_event_a: assert property ($past(dte[g]) &&
      $changed(q.port[g].tx_loc) |-> q.status[`SSPA_ST_TXLOC + g])
      else $error("clock loss change not flagged");
    loc_window_a: assert property ($rose(q.port[g].rx_loc) |->
      $past(q.port[g].rxloc_cnt) == LOC_WINDOW - 9'h1)
      else $error("clock loss raised off window");
  end

endmodule : sync_serial_pcm_port_adapter

// [verification/serial_far_end.sv]
/*
  Far-end serial equipment for all eight ports: it supplies the link
  clock and receive data in the follower role, or holds a level.
  Assumes the bench merges its clocks with the block's pin drivers.
*/
`timescale 1ns/100ps

module serial_far_end (
  output logic [7:0] link_clock_pos,
  output logic [7:0] link_clock_neg,
  output logic [7:0] link_data_pos,
  output logic [7:0] link_data_neg
);
  // ****************************************************************
  // Link stimulus
  // ****************************************************************

  // Clock and data idle low.
  initial begin
    link_clock_pos = 8'h00;
    link_clock_neg = 8'hff;
    link_data_pos = 8'h00;
    link_data_neg = 8'hff;
  end

  // Sends n bits, bit 0 first, on a 200 ns clock. Data moves with the
  // falling edge so it is steady around the rising edge that samples it.
  task automatic send_byte(input logic [7:0] bits, input int n);
    int k;
    #7;
    for (k = 0; k < n; k++) begin
      link_data_pos = {8{bits[k]}};
      link_data_neg = {8{~bits[k]}};
      #100;
      link_clock_pos = 8'hff;
      link_clock_neg = 8'h00;
      #100;
      link_clock_pos = 8'h00;
      link_clock_neg = 8'hff;
    end
    // Released data shows the inverse of the last bit.
    link_data_pos = {8{~bits[n - 1]}};
    link_data_neg = {8{bits[n - 1]}};
  endtask : send_byte

  // Holds one data level on every port.
  task automatic hold_level(input logic v);
    #7;
    link_data_pos = {8{v}};
    link_data_neg = {8{~v}};
  endtask : hold_level

endmodule : serial_far_end

// [verification/sync_serial_pcm_port_adapter_test.sv]
/*
  Self-checking bench of the serial port adapter: registers, clock loss,
  follower packing modes, source clock periods and both loopbacks.
  Assumes the design files and far-end model are compiled first.
*/
`timescale 1ns/100ps
`include "sspa_consts.svh"

module sync_serial_pcm_port_adapter_test;
  import sspa_pkg::*;

  localparam int PER64 = `SSPA_PERIOD64_TICKS * `SSPA_TICK_DIV;
  localparam int PER56 = `SSPA_PERIOD56_TICKS * `SSPA_TICK_DIV;

  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq, lv;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] transmit_clock_pos_seen, transmit_clock_neg_seen;
  logic [7:0] transmit_clock_pos_drive, transmit_clock_neg_drive;
  logic [7:0] transmit_clock_pos_enable, transmit_clock_neg_enable;
  logic [7:0] receive_clock_pos_seen, receive_clock_neg_seen;
  logic [7:0] receive_clock_pos_drive, receive_clock_neg_drive;
  logic [7:0] receive_clock_pos_enable, receive_clock_neg_enable;
  logic [7:0] transmit_serial_pos, transmit_serial_neg;
  logic [7:0] receive_serial_pos, receive_serial_neg, far_pos, far_neg;
  logic [7:0] pcm_rx_write, pcm_rx_room, pcm_tx_read, pcm_tx_avail;
  logic [63:0] pcm_rx_byte, pcm_tx_byte, got;
  logic [15:0] wr;
  logic [23:0] clock_absent_detect;
  int error_cnt, cmp_count, n, p;

  // ****************************************************************
  // Harness
  // ****************************************************************

  // A clock pin carries the block's driver while enabled, else the far end.
  assign transmit_clock_pos_seen = (transmit_clock_pos_enable &
    transmit_clock_pos_drive) | (~transmit_clock_pos_enable & far_pos);
  assign transmit_clock_neg_seen = (transmit_clock_neg_enable &
    transmit_clock_neg_drive) | (~transmit_clock_neg_enable & far_neg);
  assign receive_clock_pos_seen = (receive_clock_pos_enable &
    receive_clock_pos_drive) | (~receive_clock_pos_enable & far_pos);
  assign receive_clock_neg_seen = (receive_clock_neg_enable &
    receive_clock_neg_drive) | (~receive_clock_neg_enable & far_neg);

  // A short loss window keeps the run brief.
  sync_serial_pcm_port_adapter #(.LOC_WINDOW(9'd20)) DUT (
    .sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
    .transmit_clock_pos_seen, .transmit_clock_neg_seen,
    .transmit_clock_pos_drive, .transmit_clock_neg_drive,
    .transmit_clock_pos_enable, .transmit_clock_neg_enable,
    .receive_clock_pos_seen, .receive_clock_neg_seen,
    .receive_clock_pos_drive, .receive_clock_neg_drive,
    .receive_clock_pos_enable, .receive_clock_neg_enable,
    .transmit_serial_pos, .transmit_serial_neg, .receive_serial_pos,
    .receive_serial_neg, .pcm_rx_byte, .pcm_rx_write, .pcm_rx_room,
    .pcm_tx_byte, .pcm_tx_read, .pcm_tx_avail, .clock_absent_detect
  );

  serial_far_end far (
    .link_clock_pos(far_pos), .link_clock_neg(far_neg),
    .link_data_pos(receive_serial_pos), .link_data_neg(receive_serial_neg)
  );

  // The 40 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk

  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // A wait that ran out is a mismatch and ends the run.
  task automatic give_up();
    chk(64'h0, 64'h1);
    print_verdict();
  endtask : give_up

  // One Avalon transfer, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int k;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    avs_byteenable <= be;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) give_up();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask : rreg

  // Expected PCM byte for n serial bits, bit 0 of b sent first.
  function automatic logic [7:0] pack(input logic [7:0] b, input logic r56,
    input logic rev);
    logic [7:0] e;
    e = 8'h00;
    for (int k = 0; k < (r56 ? 7 : 8); k++) begin
      if (rev) e[r56 ? k + 1 : k] = b[k];
      else e[7 - k] = b[k];
    end
    return e;
  endfunction : pack

  // Waits for a PCM receive write and keeps the byte and both strobes.
  task automatic catch_rx(input int lim);
    int k;
    for (k = 0; k < lim && pcm_rx_write === 8'h00; k++) @(posedge sys_clk);
    if (pcm_rx_write === 8'h00) give_up();
    got = pcm_rx_byte;
    wr = {pcm_rx_write, pcm_tx_read};
  endtask : catch_rx

  // One follower frame on all ports; full ports must drop and slip.
  task automatic rx_run(input logic [7:0] b, input logic r56,
    input logic [7:0] rev);
    repeat (120) @(posedge sys_clk);
    bus(1'b0, `SSPA_STATUS_OFS, 32'h0, 4'hf);
    fork
      far.send_byte(b, r56 ? 7 : 8);
      catch_rx(400);
    join
    rreg(`SSPA_LOC_OFS, 32'h0);
    chk(wr[15:8], pcm_rx_room);
    for (p = 0; p < 8; p++)
      if (pcm_rx_room[p]) chk(got[8*p +: 8], pack(b, r56, rev[p]));
    rreg(`SSPA_STATUS_OFS, {8'h00, ~pcm_rx_room, 16'hffff});
  endtask : rx_run

  // Cycles between two rising edges of a port's generated clock.
  task automatic period(input int pt, input int e);
    int t;
    int k;
    logic pv;
    t = -1;
    pv = 1'b1;
    for (k = 0; k < 2000; k++) begin
      @(posedge sys_clk);
      if (transmit_clock_pos_drive[pt] === 1'b1 && pv === 1'b0) begin
        if (t > 0) break;
        t = 0;
      end
      if (t >= 0) t++;
      pv = transmit_clock_pos_drive[pt];
    end
    if (k == 2000) give_up();
    chk(t, e);
    chk(receive_clock_pos_drive[pt], 1'b1);
    chk(transmit_clock_neg_drive[pt], 1'b0);
  endtask : period

  // ****************************************************************
  // Main sequence
  // ****************************************************************

  // Follower tests come first, while the receive counters are at bit 0.
  initial begin
    arst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    pcm_rx_room = 8'hff;
    pcm_tx_avail = 8'hff;
    pcm_tx_byte = 64'h8c_a5_3c_96_f0_0f_5a_c3;
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk({transmit_clock_pos_enable, receive_clock_neg_enable}, 16'hffff);
    rreg(`SSPA_CTRL_OFS, 32'h0);
    rreg(`SSPA_STATUS_OFS, 32'h0);
    rreg(4'h6, 32'h0);
    bus(1'b1, `SSPA_LOC_OFS, 32'hffff_ffff, 4'hf);
    rreg(`SSPA_LOC_OFS, 32'h0);
    $display("Test reset and map done");
    bus(1'b1, `SSPA_MASK_OFS, 32'h0000_ffff, 4'hf);
    bus(1'b1, `SSPA_CTRL_OFS, 32'h0000_ff00, 4'hf);
    for (n = 0; n < 400 && clock_absent_detect[15:0] !== 16'hffff; n++)
      @(posedge sys_clk);
    chk(clock_absent_detect[15:0], 16'hffff);
    chk(irq, 1'b1);
    bus(1'b1, `SSPA_MASK_OFS, 32'h0, 4'hf);
    chk(irq, 1'b0);
    bus(1'b1, `SSPA_MASK_OFS, 32'h0000_ffff, 4'hf);
    rreg(`SSPA_LOC_OFS, 32'h0000_ffff);
    rreg(`SSPA_STATUS_OFS, 32'h0000_ffff);
    chk(irq, 1'b0);
    $display("Test clock loss done");
    bus(1'b1, `SSPA_CTRL_OFS, 32'h000f_ff00, 4'hf);
    rx_run(8'h4d, 1'b0, 8'h0f);
    bus(1'b1, `SSPA_CTRL_OFS, 32'h00f0_ff00, 4'hf);
    bus(1'b1, `SSPA_CTRL_OFS, 32'h0000_00ff, 4'h1);
    rreg(`SSPA_CTRL_OFS, 32'h00f0_ffff);
    pcm_rx_room <= 8'h0f;
    rx_run(8'h6b, 1'b1, 8'hf0);
    pcm_rx_room <= 8'hff;
    $display("Test follower reception done");
    bus(1'b1, `SSPA_CTRL_OFS, 32'h0000_000f, 4'hf);
    bus(1'b0, `SSPA_STATUS_OFS, 32'h0, 4'hf);
    chk(transmit_clock_pos_enable, 8'hff);
    period(0, PER56);
    period(7, PER64);
    rreg(`SSPA_STATUS_OFS, 32'h0);
    rreg(`SSPA_LOC_OFS, 32'h0);
    $display("Test source clocks done");
    bus(1'b1, `SSPA_CTRL_OFS, 32'hff00_0000, 4'hf);
    lv = 1'b1;
    repeat (2) begin
      far.hold_level(lv);
      @(posedge sys_clk);
      for (n = 0; n < 40 && transmit_serial_pos !== {8{lv}}; n++)
        @(posedge sys_clk);
      chk(transmit_serial_pos, {8{lv}});
      chk(transmit_serial_neg, {8{~lv}});
      lv = ~lv;
    end
    catch_rx(6000);
    chk(wr[15:8], wr[7:0]);
    for (p = 0; p < 8; p++)
      if (wr[8 + p]) chk(got[8*p +: 8], pcm_tx_byte[8*p +: 8]);
    $display("Test loopback done");
    print_verdict();
  end

endmodule : sync_serial_pcm_port_adapter_test
